// *** rofm_bank.v ***
// Level/override register and first fault mask register with their effects.
// Assumes a same-clock register port from the serial control logic;
// rail control and fault inputs come from pins or other domains.
module rofm_bank (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_ce,
  input wire [7:0] i_addr,
  input wire i_wr,
  input wire [7:0] i_wdata,
  input wire i_rd,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  input wire [7:0] i_factory_level_override,
  input wire [7:0] i_factory_fault_mask,
  input wire [3:0] i_pin_is_sw_controlled,
  input wire [3:0] i_pin_is_open_drain,
  input wire [3:0] i_pg_tree_level,
  input wire i_shared_is_switch_b_two,
  input wire [3:0] i_rail_seq_enable,
  input wire [3:0] i_rail_kill,
  input wire [7:0] i_rail_fault,
  output reg [3:0] o_pin_out,
  output reg [3:0] o_pin_oe,
  output reg o_term_reg_on,
  output reg o_switch_b_two_on,
  output reg o_general_ldo_one_on,
  output reg o_switch_b_one_on,
  output reg o_ldo_three_on,
  output reg o_fault_shutdown,
  output reg [7:0] o_fault_seen
);
`include "rofm_regs.vh"
  // ********************
  // Input synchronisers
  // ********************
  // Control levels and faults arrive from outside the clock domain
  reg [3:0] seq_s1;
  reg [3:0] seq_s2;
  reg [3:0] pg_s1;
  reg [3:0] pg_s2;
  reg [7:0] flt_s1;
  reg [7:0] flt_s2;
  reg init_done;
  reg load_default;
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      seq_s1 <= 4'h0;
      seq_s2 <= 4'h0;
      pg_s1 <= 4'h0;
      pg_s2 <= 4'h0;
      flt_s1 <= 8'h00;
      flt_s2 <= 8'h00;
      init_done <= 1'b0;
      load_default <= 1'b0;
    end else if (i_ce) begin
      seq_s1 <= i_rail_seq_enable;
      seq_s2 <= seq_s1;
      pg_s1 <= i_pg_tree_level;
      pg_s2 <= pg_s1;
      flt_s1 <= i_rail_fault;
      flt_s2 <= flt_s1;
      // Factory contents are caught once, on the second edge after release
      load_default <= ~init_done;
      init_done <= 1'b1;
    end
  end
  // ********************
  // Register file
  // ********************
  wire [7:0] lvl_ovr;
  wire [7:0] fmask;
  wire hit_lvl = (i_addr == `ROFM_OFS_LEVEL_OVERRIDE);
  wire hit_msk = (i_addr == `ROFM_OFS_FAULT_MASK);
  rofm_byte_reg u_lvl_ovr (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_load_default(load_default),
    .i_default(i_factory_level_override),
    .i_wr(i_wr & hit_lvl),
    .i_wdata(i_wdata),
    .o_q(lvl_ovr)
  );
  rofm_byte_reg u_fmask (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_load_default(load_default),
    .i_default(i_factory_fault_mask),
    .i_wr(i_wr & hit_msk),
    .i_wdata(i_wdata),
    .o_q(fmask)
  );
  // Read answer one cycle after the strobe; unmapped offsets read zero
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= `ROFM_READ_IDLE;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        if (hit_lvl) begin
          o_rdata <= lvl_ovr;
        end else if (hit_msk) begin
          o_rdata <= fmask;
        end else begin
          o_rdata <= `ROFM_READ_IDLE;
        end
      end
    end
  end
  // ********************
  // Pin drive
  // ********************
  function [1:0] pin_drive;
    input sw_ctl;
    input od;
    input level;
    input pg;
    reg val;
    begin
      val = sw_ctl ? level : pg;
      // Open drain releases for a high, so the enable carries the low
      pin_drive = od ? {1'b0, ~val} : {val, 1'b1};
    end
  endfunction
  wire [3:0] levels = {lvl_ovr[`ROFM_BIT_PIN4_LEVEL], lvl_ovr[`ROFM_BIT_PIN3_LEVEL],
    lvl_ovr[`ROFM_BIT_PIN2_LEVEL], lvl_ovr[`ROFM_BIT_PIN1_LEVEL]};
  reg [3:0] next_pin_out;
  reg [3:0] next_pin_oe;
  reg [1:0] drv;
  integer k;
  always @* begin
    next_pin_out = 4'h0;
    next_pin_oe = 4'h0;
    drv = 2'b00;
    for (k = 0; k < `ROFM_PIN_W; k = k + 1) begin
      drv = pin_drive(i_pin_is_sw_controlled[k], i_pin_is_open_drain[k], levels[k], pg_s2[k]);
      next_pin_out[k] = drv[1];
      next_pin_oe[k] = drv[0];
    end
    // Pin four only exists as an open-drain output
    next_pin_out[3] = 1'b0;
    next_pin_oe[3] = i_pin_is_sw_controlled[3] ? ~levels[3] : ~pg_s2[3];
  end
  // ********************
  // Rail enables
  // ********************
  // Kill low wins, then override, then pin or sequencer
  function rail_on;
    input kill_n;
    input force_on;
    input seq;
    begin
      rail_on = kill_n & (force_on | seq);
    end
  endfunction
  // Index 3 term, 2 shared slot, 1 switch b one, 0 ldo three
  // Own loop index, so the two decode processes share no variable
  reg [3:0] next_rail;
  integer r;
  always @* begin
    next_rail = 4'h0;
    for (r = 0; r < `ROFM_RAIL_W; r = r + 1) begin
      next_rail[r] = rail_on(i_rail_kill[r], lvl_ovr[r], seq_s2[r]);
    end
  end
  // ********************
  // Fault shutdown
  // ********************
  // Bit order: ldo two, switch a one, step-down six down to one
  wire [7:0] live_fault = flt_s2 & ~fmask;
  // Registered outputs: every effect lands one edge after the write
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pin_out <= 4'h0;
      o_pin_oe <= 4'h0;
      o_term_reg_on <= 1'b0;
      o_switch_b_two_on <= 1'b0;
      o_general_ldo_one_on <= 1'b0;
      o_switch_b_one_on <= 1'b0;
      o_ldo_three_on <= 1'b0;
      o_fault_shutdown <= 1'b0;
      o_fault_seen <= 8'h00;
    end else if (i_ce) begin
      o_pin_out <= next_pin_out;
      o_pin_oe <= next_pin_oe;
      o_term_reg_on <= next_rail[`ROFM_BIT_TERM_FORCE];
      o_switch_b_two_on <= next_rail[`ROFM_BIT_SHARED_FORCE] & i_shared_is_switch_b_two;
      o_general_ldo_one_on <= next_rail[`ROFM_BIT_SHARED_FORCE] & ~i_shared_is_switch_b_two;
      o_switch_b_one_on <= next_rail[`ROFM_BIT_SWITCH_B_ONE_FORCE];
      o_ldo_three_on <= next_rail[`ROFM_BIT_LDO3_FORCE];
      o_fault_shutdown <= |live_fault;
      o_fault_seen <= live_fault;
    end
  end
endmodule // rofm_bank

// *** rofm_regs.vh ***
// Register map constants for the rail override and fault mask bank.
// Assumes inclusion by bare name from the bank's design files.
`ifndef ROFM_REGS_VH
`define ROFM_REGS_VH
// ********************
// Offsets
// ********************
`define ROFM_ADDR_W 8
`define ROFM_OFS_LEVEL_OVERRIDE 8'ha1
`define ROFM_OFS_FAULT_MASK 8'ha2
// ********************
// Level and override fields
// ********************
`define ROFM_BIT_PIN4_LEVEL 7
`define ROFM_BIT_PIN3_LEVEL 6
`define ROFM_BIT_PIN2_LEVEL 5
`define ROFM_BIT_PIN1_LEVEL 4
`define ROFM_BIT_TERM_FORCE 3
`define ROFM_BIT_SHARED_FORCE 2
`define ROFM_BIT_SWITCH_B_ONE_FORCE 1
`define ROFM_BIT_LDO3_FORCE 0
`define ROFM_RAIL_W 4
`define ROFM_PIN_W 4
`define ROFM_FAULT_W 8
// ********************
// Reset values (factory contents are strap inputs)
// ********************
`define ROFM_RESET_BYTE 8'h00
`define ROFM_READ_IDLE 8'h00
`endif

// *** rofm_byte_reg.v ***
// One 8-bit read/write register with a load strobe.
// Assumes the factory default is a stable level caught after reset release.
module rofm_byte_reg (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_ce,
  input wire i_load_default,
  input wire [7:0] i_default,
  input wire i_wr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_q
);
`include "rofm_regs.vh"
  // ********************
  // Storage
  // ********************
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_q <= `ROFM_RESET_BYTE;
    end else if (i_ce) begin
      // Write wins over a same-cycle default load, so that write is not lost
      if (i_wr) begin
        o_q <= i_wdata;
      end else if (i_load_default) begin
        o_q <= i_default;
      end
    end
  end
endmodule // rofm_byte_reg

// *** rofm_asserts.sv ***
// Checker for the level/override and fault mask bank.
// Assumes a bind onto rofm_bank and sees its ports only.
module rofm_asserts (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_ce,
  input wire [7:0] i_addr,
  input wire i_wr,
  input wire [7:0] i_wdata,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_rvalid,
  input wire [3:0] i_pin_is_sw_controlled,
  input wire [3:0] i_pin_is_open_drain,
  input wire i_shared_is_switch_b_two,
  input wire [3:0] i_rail_kill,
  input wire [3:0] o_pin_out,
  input wire [3:0] o_pin_oe,
  input wire o_term_reg_on,
  input wire o_switch_b_two_on,
  input wire o_fault_shutdown,
  input wire [7:0] o_fault_seen
);
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Write then one live cycle: outputs follow on the next edge
  sequence s_wr1;
    i_ce && i_wr && i_addr == 8'ha1 ##1 i_ce;
  endsequence
  AST_PIN4: assert property (s_wr1 ##0 i_pin_is_sw_controlled[3]
    |=> !o_pin_out[3] && o_pin_oe[3] == !$past(i_wdata[7], 2)) else $error("pin4 level");
  AST_PIN2: assert property (s_wr1 ##0 i_pin_is_sw_controlled[1]
    && !i_pin_is_open_drain[1] |=> o_pin_out[1] == $past(i_wdata[5], 2) && o_pin_oe[1])
    else $error("pin2 level");
  AST_FORCE: assert property (s_wr1 ##0 i_rail_kill[3] && $past(i_wdata[3])
    |=> o_term_reg_on) else $error("force on");
  AST_KILL: assert property (i_ce && !i_rail_kill[3] |=> !o_term_reg_on)
    else $error("kill");
  AST_SLOT: assert property (o_switch_b_two_on && $past(i_ce) |-> $past(i_shared_is_switch_b_two))
    else $error("slot select");
  AST_MASK: assert property (i_ce && i_wr && i_addr == 8'ha2 && i_wdata == 8'hff
    ##1 i_ce |=> o_fault_seen == 8'h00) else $error("mask all");
  AST_SHUT: assert property (o_fault_shutdown == (o_fault_seen != 8'h00))
    else $error("shutdown");
  AST_RVALID: assert property (i_ce && i_rd |=> o_rvalid) else $error("rvalid");
  AST_UNMAP: assert property (i_ce && i_rd && i_addr != 8'ha1 && i_addr != 8'ha2
    |=> o_rdata == 8'h00) else $error("unmapped");
  AST_READ: assert property (s_wr1 ##0 i_rd && !i_wr && i_addr == 8'ha1
    |=> o_rdata == $past(i_wdata, 2)) else $error("readback");
endmodule // rofm_asserts

// *** testbench.sv ***
// Self-checking bench for the level/override and fault mask bank.
// Assumes rofm_bank and rofm_asserts compile alongside.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] a1; logic [3:0] kill; logic [3:0] seq; logic sel;
    logic [7:0] mask; logic [7:0] flt; logic [4:0] rails; logic [7:0] seen;
  } rofm_row_t;
  rofm_row_t rows [6] = '{'{8'h5f, 4'hf, 4'h0, 1'b1, 8'h00, 8'h01, 5'b11011, 8'h01},
    '{8'ha0, 4'hf, 4'h5, 1'b0, 8'hff, 8'hff, 5'b00101, 8'h00},
    '{8'hff, 4'h0, 4'hf, 1'b1, 8'h0f, 8'h81, 5'b00000, 8'h80},
    '{8'h0a, 4'h7, 4'h0, 1'b0, 8'h80, 8'hc0, 5'b00010, 8'h40},
    '{8'h34, 4'hf, 4'h0, 1'b0, 8'h7e, 8'h81, 5'b00100, 8'h81},
    '{8'hc8, 4'he, 4'h1, 1'b1, 8'h00, 8'h00, 5'b10000, 8'h00}};
  logic i_clk_sys = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_shared_is_switch_b_two = 1'b1;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_rail_fault = 8'h00;
  logic [7:0] i_factory_level_override = 8'h3c, i_factory_fault_mask = 8'hc3;
  logic [3:0] i_pin_is_sw_controlled = 4'hf, i_pin_is_open_drain = 4'hc;
  logic [3:0] i_pg_tree_level = 4'h0, i_rail_seq_enable = 4'h0, i_rail_kill = 4'hf;
  wire [7:0] o_rdata, o_fault_seen;
  wire [3:0] o_pin_out, o_pin_oe;
  wire o_rvalid, o_term_reg_on, o_switch_b_two_on, o_general_ldo_one_on;
  wire o_switch_b_one_on, o_ldo_three_on, o_fault_shutdown;
  int miscompares = 0;
  int check_count = 0;
  rofm_bank i_rofm_bank (.*);
  always #5 i_clk_sys = ~i_clk_sys;
  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Write then read back in the very next cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 check(o_rdata, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 check({o_rvalid, o_rdata[6:0]}, {1'b1, exp[6:0]});
    check(o_rdata, exp);
  endtask
  // Synced inputs need three edges, so five leaves margin
  task automatic settle;
    repeat (5) @(posedge i_clk_sys);
    #1;
  endtask
  // Expected {oe, out}: open-drain pulls low on 0, pin four always open-drain
  function automatic logic [7:0] pins(input logic [3:0] lvl, input logic [3:0] od);
    pins = {~lvl[3], ~lvl[2:0] | ~od[2:0], 1'b0, lvl[2:0] & ~od[2:0]};
  endfunction
  // ********************
  // Sequence
  // ********************
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    rd(8'ha1, 8'h3c);
    rd(8'ha2, 8'hc3);
    rd(8'ha3, 8'h00);
    foreach (rows[i]) begin
      @(posedge i_clk_sys);
      i_rail_kill <= rows[i].kill;
      i_rail_seq_enable <= rows[i].seq;
      i_shared_is_switch_b_two <= rows[i].sel;
      i_rail_fault <= rows[i].flt;
      wr(8'ha1, rows[i].a1);
      wr(8'ha2, rows[i].mask);
      settle;
      check({o_term_reg_on, o_switch_b_two_on, o_general_ldo_one_on, o_switch_b_one_on,
        o_ldo_three_on}, rows[i].rails);
      check(o_fault_seen, rows[i].seen);
      check({7'h0, o_fault_shutdown}, {7'h0, |rows[i].seen});
      check({o_pin_oe, o_pin_out}, pins(rows[i].a1[7:4], i_pin_is_open_drain));
    end
    @(posedge i_clk_sys);
    i_pin_is_sw_controlled <= 4'h0;
    i_pg_tree_level <= 4'h5;
    wr(8'ha1, 8'hf0);
    settle;
    check({o_pin_oe, o_pin_out}, pins(4'h5, i_pin_is_open_drain));
    // Frozen clock enable drops a write; an unmapped write changes nothing
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= 8'ha1;
    i_wdata <= 8'h00;
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    i_addr <= 8'ha3;
    i_wdata <= 8'hff;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    rd(8'ha1, 8'hf0);
    rd(8'ha2, 8'h00);
    @(posedge i_clk_sys);
    #1 check({7'h0, o_rvalid}, 8'h00);
    // Mid-run reset clears outputs, then factory contents come back
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    #1 check({o_term_reg_on, o_switch_b_two_on, o_general_ldo_one_on, o_switch_b_one_on,
      o_ldo_three_on}, 8'h00);
    check(o_fault_seen, 8'h00);
    check({7'h0, o_fault_shutdown}, 8'h00);
    rd(8'ha1, 8'h3c);
    rd(8'ha2, 8'hc3);
    stop_test;
  end
endmodule // testbench
bind rofm_bank rofm_asserts i_rofm_asserts (.*);
